// ### core/tape_function_sequencer.sv
// Tape function sequencer with classic Wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
module tape_function_sequencer
    import tape_seq_pkg::*;
#(
    parameter int WORD_W = 18
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic word_strobe,
    input wire logic block_end,
    input wire logic [WORD_W-1:0] tape_word,
    input wire logic mark_bad,
    input wire logic data_area,
    input wire logic end_zone,
    input wire logic parity_fail,
    input wire logic unit_dup,
    input wire logic unit_locked,
    input wire logic unit_offline,
    input wire logic timing_mark_write_setting_switch,
    input wire logic [WORD_W-1:0] dch_word,
    output logic motion_on,
    output logic dir_fwd,
    output logic write_on,
    output logic timing_gen,
    output logic wr_valid,
    output logic [WORD_W-1:0] wr_word,
    output logic [WORD_W/3-1:0] wr_mark,
    output logic dch_req,
    output logic [WORD_W-1:0] dch_rdata,
    output logic int_req,
    output logic err_skip,
    output logic done_skip
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    generate
        if (WORD_W != 18) begin : g_bad_width
            $error("WORD_W must be 18: fields and six-bit groups assume it");
        end
    endgenerate

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction : byte_mask

    function automatic logic is_write(input fn_e f);
        return (f == FN_WRITE) || (f == FN_RAW_WRITE) || (f == FN_TIMING_MARK);
    endfunction : is_write

    function automatic logic [CHK_W-1:0] fold6(input logic [WORD_W-1:0] w);
        logic [CHK_W-1:0] c;
        c = 6'h00;
        for (int i = 0; i < WORD_W / CHK_W; i++) begin
            c = c ^ w[i*CHK_W +: CHK_W];
        end
        return c;
    endfunction : fold6

    function automatic logic [WORD_W/3-1:0] mark_bits(input logic [WORD_W-1:0] w);
        logic [WORD_W/3-1:0] m;
        m = '0;
        for (int i = 0; i < WORD_W / 3; i++) begin
            m[i] = w[3*i];
        end
        return m;
    endfunction : mark_bits

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [WORD_W-1:0] wc_reg, wc_next;
    err_s err_reg, err_next;
    logic dtf_reg, dtf_next;
    seq_e state_reg, state_next;
    logic heads_off_reg, heads_off_next;
    logic ovf_blk_reg, ovf_blk_next;
    logic first_reg, first_next;
    logic [CHK_W-1:0] chk_reg, chk_next;
    logic motion_reg, motion_next;
    logic dir_reg, dir_next;
    logic write_on_reg, write_on_next;
    logic timing_reg, timing_next;
    logic wr_valid_reg, wr_valid_next;
    logic [WORD_W-1:0] wr_word_reg, wr_word_next;
    logic [WORD_W/3-1:0] wr_mark_reg, wr_mark_next;
    logic dch_req_reg, dch_req_next;
    logic [WORD_W-1:0] dch_rdata_reg, dch_rdata_next;
    logic int_req_reg, int_req_next;
    logic err_skip_reg, err_skip_next;
    logic done_skip_reg, done_skip_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic access, wr_take, load, sts_wr, wc_wr, dtf_clr;
    logic [31:0] wmask, ctrl_wval, wc_wval;
    logic [4:0] err_clr;
    fn_e fn, new_fn;
    logic go, single, xfer_fn, xfer_word, tail_word, blk, running, wc_ovf, halt;
    logic e_mark, e_eot, e_sel, e_par, e_tim;
    logic [WORD_W-1:0] wc_inc;

    assign access = wb_cyc_i & wb_stb_i;
    // Writes land on the edge that the master sees ack
    assign wr_take = access & wb_we_i & ack_reg;
    assign wmask = byte_mask(wb_sel_i);
    assign load = wr_take & (wb_adr_i == ADR_CTRL);
    assign sts_wr = wr_take & (wb_adr_i == ADR_STATUS);
    assign wc_wr = wr_take & (wb_adr_i == ADR_WC);
    assign ctrl_wval = (32'(ctrl_reg) & ~wmask) | (wb_dat_i & wmask);
    assign wc_wval = (32'(wc_reg) & ~wmask) | (wb_dat_i & wmask);
    assign dtf_clr = sts_wr & wmask[ST_DTF] & wb_dat_i[ST_DTF];
    assign err_clr = {5{sts_wr}} & wmask[ST_ERR_LSB +: 5] & wb_dat_i[ST_ERR_LSB +: 5];
    assign new_fn = fn_e'(ctrl_wval[FN_LSB +: 3]);
    assign fn = fn_e'(ctrl_reg[FN_LSB +: 3]);

    // ----------------------------------------
    // Sequencer events
    // ----------------------------------------
    assign go = ctrl_reg[GO_BIT];
    assign single = ~ctrl_reg[MODE_BIT];
    assign running = go & (state_reg != ST_IDLE) & ~load;
    assign xfer_fn = (fn == FN_READ) | (fn == FN_RAW_READ) | is_write(fn);
    assign xfer_word = word_strobe & running & (state_reg == ST_XFER) & xfer_fn;
    assign tail_word = word_strobe & running & (state_reg == ST_TAIL);
    assign blk = block_end & running & ((fn == FN_READ) | (fn == FN_WRITE));
    assign wc_inc = wc_reg + 1'b1;
    assign wc_ovf = (wc_inc == '0);

    // All marks decoded except in move and timing/mark write
    assign e_mark = word_strobe & running & mark_bad
        & (fn != FN_MOVE) & (fn != FN_TIMING_MARK);
    assign e_eot = end_zone & running & (ctrl_reg[DIR_BIT] == dir_reg);
    assign e_sel = load & ((new_fn == FN_UNUSED) | unit_dup | unit_offline
        | (is_write(new_fn) & unit_locked)
        | ((new_fn == FN_TIMING_MARK) != timing_mark_write_setting_switch));
    assign e_par = blk & (fn == FN_READ) & parity_fail;
    assign e_tim = (load & ((new_fn == FN_READ) | (new_fn == FN_WRITE)) & data_area)
        | (xfer_word & single & dtf_reg & ~dtf_clr
           & ((fn == FN_RAW_READ) | (fn == FN_RAW_WRITE)))
        | (xfer_word & single & first_reg & dtf_reg & ~dtf_clr
           & ((fn == FN_READ) | (fn == FN_WRITE)))
        | (tail_word & single & (fn == FN_TIMING_MARK));
    // Parity alone lets the tape run on
    assign halt = e_mark | e_eot | e_sel | e_tim;

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        wc_next = wc_reg;
        err_next = err_reg;
        dtf_next = dtf_reg;
        state_next = state_reg;
        heads_off_next = heads_off_reg;
        ovf_blk_next = ovf_blk_reg;
        first_next = first_reg;
        chk_next = chk_reg;
        dir_next = dir_reg;
        wr_valid_next = 1'b0;
        wr_word_next = wr_word_reg;
        wr_mark_next = wr_mark_reg;
        dch_req_next = 1'b0;
        dch_rdata_next = dch_rdata_reg;
        // Clear first so a hardware set in the same cycle wins
        if (dtf_clr) begin
            dtf_next = 1'b0;
        end
        if (load) begin
            ctrl_next = ctrl_wval[CTRL_W-1:0];
            state_next = ctrl_wval[GO_BIT] ? ST_XFER : ST_IDLE;
            heads_off_next = 1'b0;
            ovf_blk_next = 1'b0;
            first_next = 1'b1;
            chk_next = CHK_SEED;
            if (!go) begin
                dir_next = ctrl_wval[DIR_BIT];
            end
        end
        if (wc_wr) begin
            wc_next = wc_wval[WORD_W-1:0];
        end
        if (word_strobe) begin
            first_next = 1'b0;
        end
        if (xfer_word) begin
            // Counter steps before each word; overflow ends word moves
            wc_next = wc_inc;
            dch_req_next = 1'b1;
            if (wc_ovf) begin
                state_next = ST_TAIL;
                ovf_blk_next = 1'b1;
            end
            if (is_write(fn)) begin
                wr_valid_next = 1'b1;
                wr_word_next = dch_word;
                wr_mark_next = mark_bits(dch_word);
                chk_next = chk_reg ^ fold6(dch_word);
            end else begin
                dch_rdata_next = tape_word;
            end
            if ((fn != FN_READ) && (fn != FN_WRITE) && (single || wc_ovf)) begin
                dtf_next = 1'b1;
            end
        end
        if (tail_word) begin
            if (fn == FN_RAW_WRITE) begin
                heads_off_next = 1'b1;
            end else if ((fn == FN_WRITE) || (fn == FN_TIMING_MARK)) begin
                wr_valid_next = ~heads_off_reg;
                wr_word_next = '0;
                wr_mark_next = '0;
            end
        end
        if (blk) begin
            first_next = 1'b1;
            ovf_blk_next = 1'b0;
            chk_next = CHK_SEED;
            if (fn == FN_WRITE) begin
                wr_valid_next = ~heads_off_reg;
                wr_word_next = {{(WORD_W-CHK_W){1'b0}}, chk_reg};
                if (ovf_blk_reg) begin
                    heads_off_next = 1'b1;
                end
            end
            if (single || ovf_blk_reg) begin
                dtf_next = 1'b1;
            end
        end
        // Hardware set wins over a software clear in the same cycle
        err_next = err_s'(err_reg & ~err_clr);
        err_next.mark = err_next.mark | e_mark;
        err_next.end_zone = err_next.end_zone | e_eot;
        err_next.select = err_next.select | e_sel;
        err_next.parity = err_next.parity | e_par;
        err_next.timing = err_next.timing | e_tim;
        if (halt) begin
            ctrl_next[GO_BIT] = 1'b0;
            state_next = ST_IDLE;
            dtf_next = dtf_reg & ~dtf_clr;
        end
        motion_next = ctrl_next[GO_BIT];
        write_on_next = ctrl_next[GO_BIT] & (state_next != ST_IDLE)
            & is_write(fn_e'(ctrl_next[FN_LSB +: 3])) & ~heads_off_next;
        timing_next = ctrl_next[GO_BIT] & (state_next != ST_IDLE)
            & (fn_e'(ctrl_next[FN_LSB +: 3]) == FN_TIMING_MARK);
        // Enable bit gates the request, never the flags themselves
        int_req_next = ctrl_next[IE_BIT] & (dtf_next | (|err_next));
        err_skip_next = |err_next;
        done_skip_next = dtf_next;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RST;
            wc_reg <= '0;
            err_reg <= '0;
            dtf_reg <= 1'b0;
            state_reg <= ST_IDLE;
            heads_off_reg <= 1'b0;
            ovf_blk_reg <= 1'b0;
            first_reg <= 1'b1;
            chk_reg <= CHK_SEED;
            motion_reg <= 1'b0;
            dir_reg <= 1'b0;
            write_on_reg <= 1'b0;
            timing_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_word_reg <= '0;
            wr_mark_reg <= '0;
            dch_req_reg <= 1'b0;
            dch_rdata_reg <= '0;
            int_req_reg <= 1'b0;
            err_skip_reg <= 1'b0;
            done_skip_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            wc_reg <= wc_next;
            err_reg <= err_next;
            dtf_reg <= dtf_next;
            state_reg <= state_next;
            heads_off_reg <= heads_off_next;
            ovf_blk_reg <= ovf_blk_next;
            first_reg <= first_next;
            chk_reg <= chk_next;
            motion_reg <= motion_next;
            dir_reg <= dir_next;
            write_on_reg <= write_on_next;
            timing_reg <= timing_next;
            wr_valid_reg <= wr_valid_next;
            wr_word_reg <= wr_word_next;
            wr_mark_reg <= wr_mark_next;
            dch_req_reg <= dch_req_next;
            dch_rdata_reg <= dch_rdata_next;
            int_req_reg <= int_req_next;
            err_skip_reg <= err_skip_next;
            done_skip_reg <= done_skip_next;
        end
    end

    // ----------------------------------------
    // Wishbone answer
    // ----------------------------------------
    always_comb begin
        ack_next = access & ~ack_reg;
        dat_next = 32'h0000_0000;
        if (access && !ack_reg && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL: dat_next = 32'(ctrl_reg);
                ADR_STATUS: dat_next = {20'h0_0000, dtf_reg, 5'h00, err_reg, |err_reg};
                ADR_WC: dat_next = 32'(wc_reg);
                ADR_CHECK: dat_next = 32'(chk_reg);
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign motion_on = motion_reg;
    assign dir_fwd = dir_reg;
    assign write_on = write_on_reg;
    assign timing_gen = timing_reg;
    assign wr_valid = wr_valid_reg;
    assign wr_word = wr_word_reg;
    assign wr_mark = wr_mark_reg;
    assign dch_req = dch_req_reg;
    assign dch_rdata = dch_rdata_reg;
    assign int_req = int_req_reg;
    assign err_skip = err_skip_reg;
    assign done_skip = done_skip_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_rr_word;
        xfer_word && (fn == FN_RAW_READ) && !halt;
    endsequence
    sequence s_rw_last;
        xfer_word && (fn == FN_RAW_WRITE) && wc_ovf && !halt;
    endsequence

    property p_rr_single_done;
        s_rr_word and single |=> dtf_reg && dch_req_reg;
    endproperty
    a_rr_single_done: assert property (p_rr_single_done) else $error("done flag missing");
    property p_tail_no_words;
        (state_reg == ST_TAIL) && !load |=> !dch_req_reg;
    endproperty
    a_tail_no_words: assert property (p_tail_no_words) else $error("word after overflow");
    property p_rr_late_clear;
        xfer_word && (fn == FN_RAW_READ) && single && dtf_reg && !dtf_clr
            |=> err_reg.timing && !motion_reg;
    endproperty
    a_rr_late_clear: assert property (p_rr_late_clear) else $error("timing error missing");
    property p_rr_burst_quiet;
        s_rr_word and !single && !wc_ovf && !dtf_reg |=> !dtf_reg;
    endproperty
    a_rr_burst_quiet: assert property (p_rr_burst_quiet) else $error("early done in burst");
    property p_rw_last_word;
        s_rw_last |=> (state_reg == ST_TAIL) && wr_valid_reg && write_on_reg;
    endproperty
    a_rw_last_word: assert property (p_rw_last_word) else $error("last word lost");
    property p_mark_pick;
        xfer_word && (fn == FN_TIMING_MARK) |=> wr_mark_reg == mark_bits($past(dch_word));
    endproperty
    a_mark_pick: assert property (p_mark_pick) else $error("mark bits wrong");
    property p_irq_gate;
        !ctrl_reg[IE_BIT] && !load |=> !int_req_reg;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");
    property p_halt_stops;
        halt && !dtf_reg |=> !motion_reg && !ctrl_reg[GO_BIT] && !dtf_reg ##1 !write_on_reg;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("transport not stopped");
    property p_code7;
        load && (new_fn == FN_UNUSED) |=> err_reg.select && err_skip_reg;
    endproperty
    a_code7: assert property (p_code7) else $error("select error missing");

endmodule : tape_function_sequencer

// ### core/tape_seq_pkg.sv
// Shared constants and types for the tape function sequencer
package tape_seq_pkg;

    // ----------------------------------------
    // Register map and bus
    // ----------------------------------------
    localparam int ADR_W = 4;
    localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0;
    localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;
    localparam logic [ADR_W-1:0] ADR_WC = 4'h8;
    localparam logic [ADR_W-1:0] ADR_CHECK = 4'hC;

    // ----------------------------------------
    // Control word fields
    // ----------------------------------------
    localparam int CTRL_W = 18;
    localparam logic [CTRL_W-1:0] CTRL_RST = 18'h0_0000;
    localparam int DIR_BIT = 3;
    localparam int GO_BIT = 4;
    localparam int MODE_BIT = 5;
    localparam int FN_LSB = 6;
    localparam int IE_BIT = 9;

    // ----------------------------------------
    // Status word fields
    // ----------------------------------------
    localparam int ST_EF = 0;
    localparam int ST_ERR_LSB = 1;
    localparam int ST_DTF = 11;

    // ----------------------------------------
    // Check character
    // ----------------------------------------
    localparam int CHK_W = 6;
    localparam logic [CHK_W-1:0] CHK_SEED = 6'h00;

    typedef enum logic [2:0] {
        FN_MOVE = 3'h0,
        FN_SEARCH = 3'h1,
        FN_READ = 3'h2,
        FN_RAW_READ = 3'h3,
        FN_WRITE = 3'h4,
        FN_RAW_WRITE = 3'h5,
        FN_TIMING_MARK = 3'h6,
        FN_UNUSED = 3'h7
    } fn_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_TAIL = 3'b100
    } seq_e;

    // Error indicators in status bit order, msb first
    typedef struct packed {
        logic timing;
        logic parity;
        logic select;
        logic end_zone;
        logic mark;
    } err_s;

endpackage : tape_seq_pkg

// ### tb/tape_function_sequencer_test.sv
// Self-checking bench for the tape function sequencer
`timescale 1ns/10ps
module tape_function_sequencer_test;
    import tape_seq_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] dat_o, q;
    logic [3:0] sel = '0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
    logic word_strobe, block_end;
    logic [17:0] tape_word, dch_word, dch_rdata, last_tw, wr_word, last_wr;
    logic [5:0] acc;
    logic write_on, wr_valid;
    logic mark_bad = 1'b0, unit_locked = 1'b0, unit_offline = 1'b0;
    logic motion_on, dch_req, int_req, err_skip, done_skip, dirb;
    int err_total = 0;
    int cmp_count = 0;
    int nreq = 0;
    int nwr = 0;
    int base;
    int n;

    always #25 clk = ~clk;

    tape_function_sequencer tape_function_sequencer_i (.clk(clk), .resetn(resetn),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .word_strobe(word_strobe),
        .block_end(block_end), .tape_word(tape_word), .mark_bad(mark_bad),
        .data_area(1'b0), .end_zone(1'b0), .parity_fail(1'b0), .unit_dup(1'b0),
        .unit_locked(unit_locked), .unit_offline(unit_offline), .timing_mark_write_setting_switch(1'b0),
        .dch_word(dch_word), .motion_on(motion_on), .dir_fwd(), .write_on(write_on),
        .timing_gen(), .wr_valid(wr_valid), .wr_word(wr_word), .wr_mark(), .dch_req(dch_req),
        .dch_rdata(dch_rdata), .int_req(int_req), .err_skip(err_skip),
        .done_skip(done_skip));

    tape_partner tape_partner_i (.clk(clk), .resetn(resetn), .motion_on(motion_on),
        .word_strobe(word_strobe), .block_end(block_end), .tape_word(tape_word),
        .dch_word(dch_word));

    always @(posedge clk) begin
        if (word_strobe === 1'b1) last_tw <= tape_word;
        if (dch_req === 1'b1) nreq <= nreq + 1;
        if (wr_valid === 1'b1) begin
            nwr <= nwr + 1;
            last_wr <= wr_word;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, q, exp);
    endtask : rd

    task automatic wait_hi(input int which);
        // Bounded wait on done or error indication
        repeat (400) if ((which ? err_skip : done_skip) !== 1'b1) @(posedge clk);
        #1;
    endtask : wait_hi

    function automatic logic [31:0] ctl(input logic [2:0] fn, input logic b, input logic ie);
        return (32'(ie) << IE_BIT) | (32'(fn) << FN_LSB) | (32'(b) << MODE_BIT)
            | (32'h1 << GO_BIT) | (32'(dirb) << DIR_BIT);
    endfunction : ctl

    function automatic logic [5:0] fold(input logic [17:0] w);
        return w[5:0] ^ w[11:6] ^ w[17:12];
    endfunction : fold

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        #(50 * 30000);
        err_total++;
        print_verdict;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h7de3));
        dirb = 1'($urandom_range(1));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(ADR_CTRL, 32'h0000_0000, "ctrl");
        rd(ADR_STATUS, 32'h0000_0000, "status");
        wb(1'b1, 4'h2, 32'h0000_ffff);
        rd(4'h2, 32'h0000_0000, "unmapped");
        // Flag left set: next word must give a timing error
        wb(1'b1, ADR_WC, 32'h0003_fffd);
        wb(1'b1, ADR_CTRL, ctl(FN_RAW_READ, 1'b0, 1'b1));
        wait_hi(0);
        chk("int", int_req, 1);
        chk("rdata", dch_rdata, last_tw);
        wait_hi(1);
        rd(ADR_STATUS, 32'h0000_0821, "timing");
        chk("motion", motion_on, 0);
        wb(1'b1, ADR_STATUS, 32'h0000_083f);
        rd(ADR_STATUS, 32'h0000_0000, "clear");
        // Enable off: flags still set, no request
        wb(1'b1, ADR_WC, 32'h0003_ffff);
        wb(1'b1, ADR_CTRL, ctl(FN_RAW_READ, 1'b0, 1'b0));
        wait_hi(0);
        chk("int_off", int_req, 0);
        wb(1'b1, ADR_STATUS, 32'h0000_083f);
        n = nreq;
        repeat (60) @(posedge clk);
        #1;
        chk("stopped", nreq, n);
        chk("moving", motion_on, 1);
        // Burst: done only at overflow, random length
        n = 2 + $urandom_range(3);
        wb(1'b1, ADR_WC, 32'h0004_0000 - n);
        base = nreq;
        wb(1'b1, ADR_CTRL, ctl(FN_RAW_READ, 1'b1, 1'b1));
        wait_hi(0);
        chk("burst", nreq - base, n);
        repeat (60) @(posedge clk);
        #1;
        chk("burst_end", nreq - base, n);
        chk("burst_mv", motion_on, 1);
        rd(ADR_WC, 32'h0000_0000, "wc");
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_STATUS, 32'h0000_083f);
        // Burst data-write of one word: zero fill, check word, heads off
        wb(1'b1, ADR_WC, 32'h0003_ffff);
        wb(1'b1, ADR_CTRL, ctl(FN_WRITE, 1'b1, 1'b1));
        @(posedge clk iff word_strobe === 1'b1);
        acc = fold(dch_word) ^ CHK_SEED;
        wait_hi(0);
        chk("check", last_wr, 32'(acc));
        n = nwr;
        repeat (30) @(posedge clk);
        #1;
        chk("heads", write_on, 0);
        chk("wr_stop", nwr, n);
        chk("wr_mv", motion_on, 1);
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_STATUS, 32'h0000_083f);
        // Burst raw-write: overflow word is the last written
        n = 2 + $urandom_range(2);
        wb(1'b1, ADR_WC, 32'h0004_0000 - n);
        base = nwr;
        wb(1'b1, ADR_CTRL, ctl(FN_RAW_WRITE, 1'b1, 1'b1));
        wait_hi(0);
        chk("rw_words", nwr - base, n);
        chk("rw_on", write_on, 1);
        // Keep the function 25 cycles, over two word times, so a tail word turns the heads off
        repeat (25) @(posedge clk);
        #1;
        chk("rw_heads", write_on, 0);
        chk("rw_count", nwr - base, n);
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_STATUS, 32'h0000_083f);
        // Unrecognised mark halts without done
        mark_bad <= 1'b1;
        wb(1'b1, ADR_CTRL, ctl(FN_RAW_READ, 1'b0, 1'b1));
        wait_hi(1);
        rd(ADR_STATUS, 32'h0000_0003, "mark");
        mark_bad <= 1'b0;
        chk("mark_int", int_req, 1);
        chk("mark_mv", motion_on, 0);
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_STATUS, 32'h0000_083f);
        // Select cases: code 7, locked write, offline unit
        for (int i = 0; i < 3; i++) begin
            unit_locked <= (i == 1);
            unit_offline <= (i == 2);
            wb(1'b1, ADR_CTRL, ctl(i == 0 ? FN_UNUSED : i == 1 ? FN_WRITE : FN_RAW_READ,
                1'b0, 1'b1));
            wait_hi(1);
            rd(ADR_STATUS, 32'h0000_0009, "select");
            chk("sel_mv", motion_on, 0);
            chk("sel_skip", err_skip, 1);
            wb(1'b1, ADR_STATUS, 32'h0000_083f);
        end
        print_verdict;
    end
endmodule : tape_function_sequencer_test

// ### tb/tape_partner.sv
// Behavioural model of the tape transport and data channel
`timescale 1ns/10ps
module tape_partner #(
    parameter int GAP = 8,
    parameter int BLK = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic motion_on,
    output logic word_strobe,
    output logic block_end,
    output logic [17:0] tape_word,
    output logic [17:0] dch_word
);
    int cnt;
    int wn;
    // ----------------------------------------
    // Word timing
    // ----------------------------------------
    // Strobes only while moving, GAP+1 cycles apart, every BLK+1-th a block end; data lines toggle
    // between words so a stale value is never mistaken for a fresh one
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            wn <= 0;
            word_strobe <= 1'b0;
            block_end <= 1'b0;
            tape_word <= 18'h0_0000;
            dch_word <= 18'h0_0000;
        end else begin
            word_strobe <= 1'b0;
            block_end <= 1'b0;
            tape_word <= ~tape_word;
            dch_word <= ~dch_word;
            cnt <= motion_on ? cnt + 1 : 0;
            if (motion_on && cnt == GAP) begin
                cnt <= 0;
                wn <= (wn == BLK) ? 0 : wn + 1;
                block_end <= (wn == BLK);
                word_strobe <= (wn != BLK);
                tape_word <= 18'($urandom);
                dch_word <= 18'($urandom);
            end
        end
    end
endmodule : tape_partner
